// ===== hw/tmcc_pkg.sv
// shared constants and types for the timer0 mode and clock control block
package tmcc_pkg;
  // register byte addresses in the i/o space
  localparam logic [7:0] ADDR_SYNC_CTRL = 8'h43;
  localparam logic [7:0] ADDR_CTRL_B    = 8'h45;
  localparam logic [7:0] ADDR_COUNT     = 8'h46;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h6e;
  localparam logic [7:0] ADDR_FLAGS     = 8'h35;
  localparam logic [7:0] REG_RESET      = 8'h00;
  // field positions
  localparam int SYNC_HOLD_BIT  = 7;
  localparam int ASYNC_PSR_BIT  = 1;
  localparam int SHARED_PSR_BIT = 0;
  localparam int FORCE_A_BIT    = 7;
  localparam int FORCE_B_BIT    = 6;
  localparam int MODE_HI_BIT    = 3;
  localparam int CLK_SEL_LSB    = 0;
  localparam int CMP_B_BIT      = 2;
  localparam int CMP_A_BIT      = 1;
  localparam int OVF_BIT        = 0;
  // counter limits
  localparam logic [7:0] COUNT_MAX    = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_STEP   = 8'h01;
  // prescaler tap widths: a tap fires when its low bits are all one
  localparam int PS_WIDTH     = 10;
  localparam int DIV8_BITS    = 3;
  localparam int DIV64_BITS   = 6;
  localparam int DIV256_BITS  = 8;
  localparam int DIV1024_BITS = 10;
  // waveform generation modes
  typedef enum logic [2:0] {
    MODE_NORMAL    = 3'b000,
    MODE_PHASE_FF  = 3'b001,
    MODE_CLR_MATCH = 3'b010,
    MODE_FAST_FF   = 3'b011,
    MODE_RSVD_4    = 3'b100,
    MODE_PHASE_TOP = 3'b101,
    MODE_RSVD_6    = 3'b110,
    MODE_FAST_TOP  = 3'b111
  } tmcc_mode_t;
  // counter clock sources
  typedef enum logic [2:0] {
    CLK_STOP     = 3'b000,
    CLK_DIV1     = 3'b001,
    CLK_DIV8     = 3'b010,
    CLK_DIV64    = 3'b011,
    CLK_DIV256   = 3'b100,
    CLK_DIV1024  = 3'b101,
    CLK_EXT_FALL = 3'b110,
    CLK_EXT_RISE = 3'b111
  } tmcc_clk_sel_t;
endpackage

// ===== hw/tmcc_prescaler.sv
// shared free-running prescaler with divide taps
`timescale 1ns/1ps
module tmcc_prescaler (
  input  wire logic i_ref_clk, // i/o clock
  input  wire logic i_rst,     // sync reset, active high
  input  wire logic i_clear,   // prescaler reset request
  output logic      o_en8,     // divide-by-8 enable
  output logic      o_en64,    // divide-by-64 enable
  output logic      o_en256,   // divide-by-256 enable
  output logic      o_en1024   // divide-by-1024 enable
);
  import tmcc_pkg::*;

  logic [PS_WIDTH-1:0] div_reg;

  // counter held at zero while its reset is asserted
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || i_clear) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // taps decoded from the low bits, so a cleared divider restarts every rate in phase
  assign o_en8    = !i_clear && (&div_reg[DIV8_BITS-1:0]);
  assign o_en64   = !i_clear && (&div_reg[DIV64_BITS-1:0]);
  assign o_en256  = !i_clear && (&div_reg[DIV256_BITS-1:0]);
  assign o_en1024 = !i_clear && (&div_reg[DIV1024_BITS-1:0]);
endmodule

// ===== hw/tmcc_edge_sync.sv
// two-stage synchroniser and edge detector for the external count pin
`timescale 1ns/1ps
module tmcc_edge_sync (
  input  wire logic i_ref_clk, // i/o clock
  input  wire logic i_rst,     // sync reset, active high
  input  wire logic i_pin,     // asynchronous pin level
  output logic      o_rise,    // one-cycle rising edge pulse
  output logic      o_fall     // one-cycle falling edge pulse
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // only sync_reg reads meta_reg; the edge logic looks at later stages
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= i_pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // at most one pulse per clock, pin edges faster than that are lost
  assign o_rise = sync_reg && !last_reg;
  assign o_fall = !sync_reg && last_reg;
endmodule

// ===== hw/tmcc_top.sv
// timer0 mode, clock select, force compare, mask and prescaler control
// Summary of operation
// - three-bit mode field, codes 4, 6 reserved
// - normal and clear-on-match: immediate update, overflow at max
// - phase-correct: update at top, overflow at bottom
// - fast pwm: update at bottom, top per mode
// - force strobes act only in non-pwm modes
// - force strobe applies immediate match to output
// - forced match sets no flag, never clears counter
// - force strobe bits always read as zero
// - clock select: stop, five divides, external pin
// - code 6 falling edge, code 7 rising edge
// - pin edges count even when pin drives out
// - irq needs enable, global enable and flag
// - sync hold mode keeps prescaler reset bits
// - clearing sync hold loads both reset bits from the written data
// - async reset bit resets timer2 prescaler, self-clears
// - shared reset bit resets shared prescaler, self-clears
// - counter write blocks match on next tick
// - overflow flag sets on overflow, cleared by ack
`timescale 1ns/1ps
module tmcc_top (
  input  wire logic       i_ref_clk,             // i/o clock, 100 MHz
  input  wire logic       i_rst,                 // sync reset, active high
  input  wire logic [7:0] i_io_addr,             // register byte address
  input  wire logic       i_io_wr,               // write strobe
  input  wire logic       i_io_rd,               // read strobe
  input  wire logic [7:0] i_io_wdata,            // write data
  output logic      [7:0] o_io_rdata,            // read data, one cycle after strobe
  input  wire logic       i_mode_sel_mid,        // mode field middle bit
  input  wire logic       i_mode_sel_lo,         // mode field low bit
  input  wire logic [1:0] i_cmp_a_output_mode,   // channel a output mode
  input  wire logic [1:0] i_cmp_b_output_mode,   // channel b output mode
  input  wire logic [7:0] i_cmp_a_value,         // channel a compare value as written
  input  wire logic [7:0] i_cmp_b_value,         // channel b compare value as written
  input  wire logic       i_ext_count_pin,       // external count pin level
  input  wire logic       i_global_irq_en,       // cpu global interrupt enable
  input  wire logic       i_ack_ovf,             // overflow vector executed
  input  wire logic       i_ack_cmp_a,           // compare a vector executed
  input  wire logic       i_ack_cmp_b,           // compare b vector executed
  input  wire logic       i_async_mode,          // timer2 runs asynchronously
  input  wire logic       i_async_reset_done,    // timer2 prescaler reset done
  output logic            o_async_prescaler_rst, // timer2 prescaler reset
  output logic            o_shared_prescaler_rst,// timer0/1 prescaler reset
  output logic      [7:0] o_count,               // counter value
  output logic            o_wave_out_a,          // channel a waveform
  output logic            o_wave_out_b,          // channel b waveform
  output logic            o_irq_ovf,             // overflow interrupt request
  output logic            o_irq_cmp_a,           // compare a interrupt request
  output logic            o_irq_cmp_b            // compare b interrupt request
);
  import tmcc_pkg::*;
  logic          sync_hold_mode_reg;
  logic          async_psr_reg;
  logic          shared_psr_reg;
  logic          mode_sel_hi_reg;
  tmcc_clk_sel_t clk_source_sel_reg;
  logic [7:0]    count_reg;
  logic [7:0]    count_next;
  logic          dir_up_reg;
  logic          dir_up_next;
  logic          block_reg;
  logic [2:0]    irq_en_reg;
  logic [2:0]    flag_reg;
  logic [7:0]    cmp_a_eff_reg;
  logic [7:0]    cmp_b_eff_reg;
  logic          wave_a_reg;
  logic          wave_b_reg;
  logic [7:0]    rdata_reg;
  tmcc_mode_t    mode;
  logic [7:0]    top_val;
  logic          is_pwm;
  logic          is_fast;
  logic          is_phase;
  logic          at_top;
  logic          tick;
  logic          ovf_evt;
  logic          upd_evt;
  logic          bottom_evt;
  logic          match_a;
  logic          match_b;
  logic          force_a;
  logic          force_b;
  logic          wr_sync;
  logic          wr_ctrl_b;
  logic          wr_count;
  logic          wr_mask;
  logic          wr_flags;
  logic          en8;
  logic          en64;
  logic          en256;
  logic          en1024;
  logic          ext_rise;
  logic          ext_fall;
  // write decode
  assign wr_sync   = i_io_wr && (i_io_addr == ADDR_SYNC_CTRL);
  assign wr_ctrl_b = i_io_wr && (i_io_addr == ADDR_CTRL_B);
  assign wr_count  = i_io_wr && (i_io_addr == ADDR_COUNT);
  assign wr_mask   = i_io_wr && (i_io_addr == ADDR_IRQ_MASK);
  assign wr_flags  = i_io_wr && (i_io_addr == ADDR_FLAGS);
  tmcc_prescaler u_prescaler (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_clear   (shared_psr_reg),
    .o_en8     (en8),
    .o_en64    (en64),
    .o_en256   (en256),
    .o_en1024  (en1024)
  );
  // the pin is sampled as a plain level, whatever its direction
  tmcc_edge_sync u_edge_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_pin     (i_ext_count_pin),
    .o_rise    (ext_rise),
    .o_fall    (ext_fall)
  );
  // sync hold and prescaler reset bits
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sync_hold_mode_reg <= 1'b0;
      async_psr_reg      <= 1'b0;
      shared_psr_reg     <= 1'b0;
    end else if (wr_sync) begin
      sync_hold_mode_reg <= i_io_wdata[SYNC_HOLD_BIT];
      shared_psr_reg     <= i_io_wdata[SHARED_PSR_BIT];
      async_psr_reg      <= i_io_wdata[ASYNC_PSR_BIT];
    end else if (!sync_hold_mode_reg) begin
      // self-clear one cycle after set; after a hold-mode release the shared bit clears on the next cycle
      shared_psr_reg <= 1'b0;
      // asynchronous timer2 keeps the request until its prescaler confirms
      if (!i_async_mode || i_async_reset_done) begin
        async_psr_reg <= 1'b0;
      end
    end
  end
  assign o_async_prescaler_rst  = async_psr_reg;
  assign o_shared_prescaler_rst = shared_psr_reg;
  // control b: force bits are strobes and are not stored
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      mode_sel_hi_reg    <= 1'b0;
      clk_source_sel_reg <= CLK_STOP;
    end else if (wr_ctrl_b) begin
      mode_sel_hi_reg    <= i_io_wdata[MODE_HI_BIT];
      clk_source_sel_reg <= tmcc_clk_sel_t'(i_io_wdata[CLK_SEL_LSB +: 3]);
    end
  end
  // interrupt enable mask
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      irq_en_reg <= 3'h0;
    end else if (wr_mask) begin
      irq_en_reg <= i_io_wdata[2:0];
    end
  end
  // mode decode
  assign mode = tmcc_mode_t'({mode_sel_hi_reg, i_mode_sel_mid, i_mode_sel_lo});
  always_comb begin
    top_val  = COUNT_MAX;
    is_fast  = 1'b0;
    is_phase = 1'b0;
    unique case (mode)
      MODE_NORMAL:    top_val = COUNT_MAX;
      MODE_CLR_MATCH: top_val = cmp_a_eff_reg;
      MODE_PHASE_FF:  begin top_val = COUNT_MAX; is_phase = 1'b1; end
      MODE_PHASE_TOP: begin top_val = cmp_a_eff_reg; is_phase = 1'b1; end
      MODE_FAST_FF:   begin top_val = COUNT_MAX; is_fast = 1'b1; end
      MODE_FAST_TOP:  begin top_val = cmp_a_eff_reg; is_fast = 1'b1; end
      MODE_RSVD_4,
      MODE_RSVD_6:    top_val = COUNT_MAX;
    endcase
  end

  // reserved codes count as pwm so that force strobes stay inert there
  assign is_pwm = !((mode == MODE_NORMAL) || (mode == MODE_CLR_MATCH));
  assign at_top = (count_reg == top_val);
  // timer clock enable; a held prescaler reset halts every source
  always_comb begin
    tick = 1'b0;
    unique case (clk_source_sel_reg)
      CLK_STOP:     tick = 1'b0;
      CLK_DIV1:     tick = 1'b1;
      CLK_DIV8:     tick = en8;
      CLK_DIV64:    tick = en64;
      CLK_DIV256:   tick = en256;
      CLK_DIV1024:  tick = en1024;
      CLK_EXT_FALL: tick = ext_fall;
      CLK_EXT_RISE: tick = ext_rise;
    endcase
    if (shared_psr_reg) begin
      tick = 1'b0;
    end
  end

  // count sequence, overflow point and compare update point per mode
  always_comb begin
    count_next  = count_reg;
    dir_up_next = dir_up_reg;
    ovf_evt     = 1'b0;
    upd_evt     = 1'b0;
    bottom_evt  = 1'b0;
    if (tick) begin
      unique case (mode)
        MODE_NORMAL: begin
          count_next = count_reg + COUNT_STEP;
          ovf_evt    = (count_reg == COUNT_MAX);
        end
        MODE_CLR_MATCH: begin
          count_next = at_top ? COUNT_BOTTOM : count_reg + COUNT_STEP;
          ovf_evt    = (count_reg == COUNT_MAX);
        end
        MODE_FAST_FF,
        MODE_FAST_TOP: begin
          count_next = at_top ? COUNT_BOTTOM : count_reg + COUNT_STEP;
          ovf_evt    = at_top; // max in mode 3, top in mode 7
          upd_evt    = at_top; // next count is bottom
          bottom_evt = at_top;
        end
        MODE_PHASE_FF,
        MODE_PHASE_TOP: begin
          if (dir_up_reg) begin
            if (at_top) begin
              dir_up_next = 1'b0;
              count_next  = count_reg - COUNT_STEP;
              upd_evt     = 1'b1;
            end else begin
              count_next = count_reg + COUNT_STEP;
            end
          end else if (count_reg == COUNT_BOTTOM) begin
            dir_up_next = 1'b1;
            count_next  = count_reg + COUNT_STEP;
            ovf_evt     = 1'b1;
          end else begin
            count_next = count_reg - COUNT_STEP;
          end
        end
        MODE_RSVD_4,
        MODE_RSVD_6: count_next = count_reg; // undefined sequence: counter holds
      endcase
    end
  end
  // counter; a software write wins over the tick in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      count_reg  <= COUNT_BOTTOM;
      dir_up_reg <= 1'b1;
    end else begin
      count_reg  <= wr_count ? i_io_wdata : count_next;
      dir_up_reg <= is_phase ? dir_up_next : 1'b1;
    end
  end
  // match blocking after a counter write lasts until the next timer tick
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      block_reg <= 1'b0;
    end else if (wr_count) begin
      block_reg <= 1'b1;
    end else if (tick) begin
      block_reg <= 1'b0;
    end
  end
  // effective compare values: follow at once in non-pwm, buffered in pwm
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cmp_a_eff_reg <= REG_RESET;
      cmp_b_eff_reg <= REG_RESET;
    end else if (!is_pwm || upd_evt) begin
      cmp_a_eff_reg <= i_cmp_a_value;
      cmp_b_eff_reg <= i_cmp_b_value;
    end
  end
  // real matches, suppressed on the tick after a counter write
  assign match_a = tick && !block_reg && (count_reg == cmp_a_eff_reg);
  assign match_b = tick && !block_reg && (count_reg == cmp_b_eff_reg);
  assign force_a = wr_ctrl_b && i_io_wdata[FORCE_A_BIT] && !is_pwm;
  assign force_b = wr_ctrl_b && i_io_wdata[FORCE_B_BIT] && !is_pwm;
  // sticky flags; a set in the clearing cycle wins; forced matches never reach here
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      flag_reg <= 3'h0;
    end else begin
      flag_reg[OVF_BIT] <= ovf_evt ||
        (flag_reg[OVF_BIT] && !i_ack_ovf && !(wr_flags && i_io_wdata[OVF_BIT]));
      flag_reg[CMP_A_BIT] <= match_a ||
        (flag_reg[CMP_A_BIT] && !i_ack_cmp_a && !(wr_flags && i_io_wdata[CMP_A_BIT]));
      flag_reg[CMP_B_BIT] <= match_b ||
        (flag_reg[CMP_B_BIT] && !i_ack_cmp_b && !(wr_flags && i_io_wdata[CMP_B_BIT]));
    end
  end

  // interrupt requests
  assign o_irq_ovf   = i_global_irq_en && irq_en_reg[OVF_BIT] && flag_reg[OVF_BIT];
  assign o_irq_cmp_a = i_global_irq_en && irq_en_reg[CMP_A_BIT] && flag_reg[CMP_A_BIT];
  assign o_irq_cmp_b = i_global_irq_en && irq_en_reg[CMP_B_BIT] && flag_reg[CMP_B_BIT];
  // next output level of one channel from its output mode bits
  function automatic logic wave_next(input logic cur, input logic [1:0] com, input logic hit,
                                     input logic bottom, input logic fast, input logic phase,
                                     input logic up, input logic toggle_ok);
    logic res;
    res = cur;
    if (!fast && !phase) begin
      if (hit) begin
        unique case (com)
          2'h0: res = cur;
          2'h1: res = !cur;
          2'h2: res = 1'b0;
          2'h3: res = 1'b1;
        endcase
      end
    end else begin
      if (hit) begin
        unique case (com)
          2'h0: res = cur;
          2'h1: res = toggle_ok ? !cur : cur;
          2'h2: res = phase ? !up : 1'b0;
          2'h3: res = phase ? up : 1'b1;
        endcase
      end
      // bottom action after the match, so a match at top yields the bottom level
      if (fast && bottom && com[1]) begin
        res = !com[0];
      end
    end
    return res;
  endfunction

  // waveform outputs; a force acts like a match but leaves counter and flags alone
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wave_a_reg <= 1'b0;
      wave_b_reg <= 1'b0;
    end else begin
      wave_a_reg <= wave_next(wave_a_reg, i_cmp_a_output_mode, match_a || force_a, bottom_evt,
                              is_fast, is_phase, dir_up_reg, mode_sel_hi_reg);
      wave_b_reg <= wave_next(wave_b_reg, i_cmp_b_output_mode, match_b || force_b, bottom_evt,
                              is_fast, is_phase, dir_up_reg, 1'b0);
    end
  end

  assign o_wave_out_a = wave_a_reg;
  assign o_wave_out_b = wave_b_reg;
  assign o_count      = count_reg;
  // registered read port; unmapped addresses and reserved bits read zero
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rdata_reg <= REG_RESET;
    end else if (i_io_rd) begin
      unique case (i_io_addr)
        ADDR_SYNC_CTRL: rdata_reg <= {sync_hold_mode_reg, 5'h00, async_psr_reg, shared_psr_reg};
        ADDR_CTRL_B:    rdata_reg <= {4'h0, mode_sel_hi_reg, clk_source_sel_reg};
        ADDR_COUNT:     rdata_reg <= count_reg;
        ADDR_IRQ_MASK:  rdata_reg <= {5'h00, irq_en_reg};
        ADDR_FLAGS:     rdata_reg <= {5'h00, flag_reg};
        default:        rdata_reg <= REG_RESET;
      endcase
    end
  end

  assign o_io_rdata = rdata_reg;
endmodule

// ===== verif/tmcc_props.sv
// port-level assertions for the timer0 mode and clock control block
`timescale 1ns/1ps
module tmcc_props
  import tmcc_pkg::*;
(
  input wire logic       i_ref_clk,              // clock
  input wire logic       i_rst,                  // reset
  input wire logic [7:0] i_io_addr,              // address
  input wire logic       i_io_wr,                // write strobe
  input wire logic       i_io_rd,                // read strobe
  input wire logic [7:0] i_io_wdata,             // write data
  input wire logic [7:0] o_io_rdata,             // read data
  input wire logic       i_global_irq_en,        // global enable
  input wire logic       i_async_mode,           // timer2 async
  input wire logic       o_async_prescaler_rst,  // timer2 reset bit
  input wire logic       o_shared_prescaler_rst, // shared reset bit
  input wire logic [7:0] o_count,                // counter
  input wire logic       o_irq_ovf,              // overflow request
  input wire logic       o_irq_cmp_a,            // compare a request
  input wire logic       o_irq_cmp_b             // compare b request
);
  import tmcc_pkg::*;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // counter loads are excluded from the halt check
  logic cnt_wr;
  assign cnt_wr = i_io_wr && i_io_addr == ADDR_COUNT;
  // writes to the prescaler control register, split by hold mode
  sequence sync_wr_s; i_io_wr && i_io_addr == ADDR_SYNC_CTRL; endsequence
  sequence sync_free_s; sync_wr_s ##0 !i_io_wdata[SYNC_HOLD_BIT]; endsequence
  sequence sync_hold_s; sync_wr_s ##0 i_io_wdata[SYNC_HOLD_BIT]; endsequence
  shared_psr_pulse_a:
    assert property (sync_free_s ##0 i_io_wdata[SHARED_PSR_BIT] |=> o_shared_prescaler_rst ##1 !o_shared_prescaler_rst)
    else $error("shared prescaler reset bit did not self clear");
  async_psr_pulse_a:
    assert property (sync_free_s ##0 i_io_wdata[ASYNC_PSR_BIT] ##1 !i_async_mode |-> o_async_prescaler_rst ##1 !o_async_prescaler_rst)
    else $error("async prescaler reset bit did not self clear");
  sync_hold_keep_a:
    assert property (sync_hold_s ##0 i_io_wdata[1:0] == 2'b11 |=> (o_shared_prescaler_rst && o_async_prescaler_rst) [*2])
    else $error("prescaler reset bits not held in sync mode");
  halt_count_a:
    assert property (o_shared_prescaler_rst && !cnt_wr |=> $stable(o_count))
    else $error("counter moved while prescaler held in reset");
  count_load_a:
    assert property (cnt_wr |=> o_count == $past(i_io_wdata))
    else $error("counter write not loaded");
  force_read_a:
    assert property (i_io_rd && i_io_addr == ADDR_CTRL_B |=> o_io_rdata[7:6] == 2'b00)
    else $error("force strobe bits read non zero");
  irq_gate_a:
    assert property (!i_global_irq_en |-> !(o_irq_ovf || o_irq_cmp_a || o_irq_cmp_b))
    else $error("interrupt requested with global enable low");
  irq_mask_a:
    assert property (i_io_wr && i_io_addr == ADDR_IRQ_MASK && !i_io_wdata[OVF_BIT] |=> !o_irq_ovf)
    else $error("overflow request with its enable cleared");
endmodule
bind tmcc_top tmcc_props u_props (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
  .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata), .i_global_irq_en(i_global_irq_en),
  .i_async_mode(i_async_mode), .o_async_prescaler_rst(o_async_prescaler_rst),
  .o_shared_prescaler_rst(o_shared_prescaler_rst), .o_count(o_count), .o_irq_ovf(o_irq_ovf),
  .o_irq_cmp_a(o_irq_cmp_a), .o_irq_cmp_b(o_irq_cmp_b));

// ===== verif/tmcc_pin_model.sv
// model of whatever drives the external count pin
`timescale 1ns/1ps
module tmcc_pin_model (
  output logic o_pin // count pin level
);
  // the pin rests low until a burst is asked for
  initial o_pin = 1'b0;
  // gaps of several clocks so the synchroniser sees every level
  task automatic edges(input int n, input int gap_ns);
    repeat (n) begin
      #(gap_ns);
      o_pin = ~o_pin;
    end
  endtask
endmodule

// ===== verif/testbench.sv
// self-checking bench for the timer0 mode and clock control block
`timescale 1ns/1ps
module testbench;
  import tmcc_pkg::*;
  // one compare: counted, a miss reported at once
  `define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
  logic       clk = 0, rst = 1, wr = 0, rd = 0, mid = 0, lo = 0, gie = 0, ack_o = 0, amode = 0, adone = 0;
  logic [7:0] addr = 0, wdata = 0, cva = 8'h10, cvb = 8'h20, rdata, cnt, r, v, lb, hb;
  logic [1:0] oma = 0, omb = 0;
  logic       pin, apsr, spsr, wa, wb, pa, pb, irq_o, irq_a, irq_b;
  logic [2:0] mt [5] = '{3'd2, 3'd7, 3'd3, 3'd1, 3'd4};
  int         n_fail = 0, comparisons = 0, seed = 6564, n, d, cyc;
  tmcc_pin_model u_pin (.o_pin(pin));
  tmcc_top u_dut (
    .i_ref_clk(clk), .i_rst(rst), .i_io_addr(addr), .i_io_wr(wr), .i_io_rd(rd), .i_io_wdata(wdata),
    .o_io_rdata(rdata), .i_mode_sel_mid(mid), .i_mode_sel_lo(lo), .i_cmp_a_output_mode(oma),
    .i_cmp_b_output_mode(omb), .i_cmp_a_value(cva), .i_cmp_b_value(cvb), .i_ext_count_pin(pin),
    .i_global_irq_en(gie), .i_ack_ovf(ack_o), .i_ack_cmp_a(1'b0), .i_ack_cmp_b(1'b0),
    .i_async_mode(amode), .i_async_reset_done(adone), .o_async_prescaler_rst(apsr),
    .o_shared_prescaler_rst(spsr), .o_count(cnt), .o_wave_out_a(wa), .o_wave_out_b(wb),
    .o_irq_ovf(irq_o), .o_irq_cmp_a(irq_a), .o_irq_cmp_b(irq_b));
  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  // level after a forced match in the non-pwm modes
  function automatic logic exp_wave(input logic [1:0] om, input logic prev);
    return (om == 2'b01) ? ~prev : (om == 2'b00) ? prev : om[0];
  endfunction
  // selected edges among n toggles from a known start level
  function automatic logic [7:0] exp_edges(input int n, input logic start, input logic rise);
    return 8'((rise ^ start) ? (n + 1) / 2 : n / 2);
  endfunction
  // divide ratio per clock select code, zero when stopped
  function automatic int div_of(input int cs);
    int t [6] = '{0, 1, 8, 64, 256, 1024};
    return t[cs];
  endfunction
  // bus cycles: strobe for one clock, inputs move just after the edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] dt);
    @(posedge clk);
    #1;
    wr = 1'b1;
    addr = a;
    wdata = dt;
    @(posedge clk);
    #1;
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] dt);
    @(posedge clk);
    #1;
    rd = 1'b1;
    addr = a;
    @(posedge clk);
    #1;
    rd = 1'b0;
    dt = rdata;
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // configure under hold so all sources start together
  task automatic start_run(input logic [7:0] cb, input logic [7:0] c0);
    wr_reg(ADDR_SYNC_CTRL, 8'h83);
    wr_reg(ADDR_COUNT, c0);
    wr_reg(ADDR_FLAGS, 8'h07);
    wr_reg(ADDR_CTRL_B, cb);
    wr_reg(ADDR_SYNC_CTRL, 8'h00);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    tally_and_finish;
  end
  initial begin
    idle(20);
    rst = 1'b0;
    foreach (mt[i]) begin
      rd_reg(8'h43 + 8'(i), r);
      `CHK("reset_value", REG_RESET, r)
    end
    wr_reg(ADDR_IRQ_MASK, 8'hfe);
    rd_reg(ADDR_IRQ_MASK, r);
    `CHK("irq_mask", 8'h06, r)
    v = 8'($random(seed));
    wr_reg(ADDR_COUNT, v);
    cva = v;
    // forced matches with the counter stopped, output modes 1 to 3 on both channels
    for (int k = 0; k < 6; k++) begin
      oma = 2'(k % 3 + 1);
      omb = 2'((k + 1) % 3 + 1);
      mid = (k >= 3);
      pa = wa;
      pb = wb;
      wr_reg(ADDR_CTRL_B, 8'hc0);
      `CHK("wave_a", exp_wave(oma, pa), wa)
      `CHK("wave_b", exp_wave(omb, pb), wb)
      rd_reg(ADDR_FLAGS, r);
      `CHK("force_flags", 2'b00, r[2:1])
      `CHK("force_count", v, cnt)
    end
    lo = 1'b1;
    pa = wa;
    wr_reg(ADDR_CTRL_B, 8'hc8);
    `CHK("pwm_force", pa, wa)
    rd_reg(ADDR_CTRL_B, r);
    `CHK("ctrl_b_read", 8'h08, r)
    {mid, lo} = 2'b00;
    cva = 8'h10;
    // internal sources: for dividers 8 to 1024 a window of three and a half periods holds three ticks
    for (int cs = 0; cs < 6; cs++) begin
      d = div_of(cs);
      cyc = (d > 1) ? 3 * d + d / 2 : 20;
      start_run(8'(cs), 8'h00);
      idle(cyc);
      wr_reg(ADDR_CTRL_B, 8'h00);
      n = (d == 0) ? 0 : (cyc + 2) / d;
      rd_reg(ADDR_COUNT, r);
      `CHK("count_window", n, int'(r))
    end
    // pin edges, an odd count so falling and rising totals differ
    for (int cs = 6; cs < 8; cs++) begin
      n = 2 * ($unsigned($random(seed)) % 4) + 3;
      pa = pin;
      start_run(8'(cs), 8'h00);
      u_pin.edges(n, 10 * (4 + $unsigned($random(seed)) % 6));
      idle(6);
      wr_reg(ADDR_CTRL_B, 8'h00);
      rd_reg(ADDR_COUNT, r);
      `CHK("ext_count", exp_edges(n, pa, cs[0]), r)
    end
    // top and overflow point of modes 2, 7, 3, 1 and reserved 4 over 40 single-clock ticks
    foreach (mt[i]) begin
      {mid, lo} = mt[i][1:0];
      lb = (mt[i] == 3'd3 || mt[i] == 3'd1) ? 8'h11 : 8'h00;
      hb = (mt[i] == 3'd4) ? 8'h00 : (lb == 8'h00) ? 8'h10 : 8'hff;
      start_run({4'h0, mt[i][2], 3'b001}, 8'h00);
      idle(40);
      wr_reg(ADDR_CTRL_B, {4'h0, mt[i][2], 3'b000});
      rd_reg(ADDR_FLAGS, r);
      `CHK("ovf_flag", (mt[i] == 3'd7), r[OVF_BIT])
      rd_reg(ADDR_COUNT, r);
      `CHK("count_range", 1'b1, (r >= lb) && (r <= hb))
    end
    // overflow request: gated, then cleared by vector and by writing one
    {mid, lo} = 2'b00;
    wr_reg(ADDR_IRQ_MASK, 8'h01);
    for (int w = 0; w < 2; w++) begin
      start_run(8'h01, 8'hf0 | 8'($random(seed) & 15));
      idle(30);
      wr_reg(ADDR_CTRL_B, 8'h00);
      `CHK("irq_gated", 1'b0, irq_o)
      gie = 1'b1;
      idle(1);
      `CHK("irq_set", 1'b1, irq_o)
      ack_o = (w == 0);
      if (w == 1) wr_reg(ADDR_FLAGS, 8'h01);
      idle(1);
      ack_o = 1'b0;
      `CHK("irq_clear", 1'b0, irq_o)
      gie = 1'b0;
    end
    // a count loaded equal to channel b skips that match only
    for (int w = 0; w < 2; w++) begin
      start_run(8'h01, cvb - 8'(w));
      idle(2);
      rd_reg(ADDR_FLAGS, r);
      `CHK("skip_match", w, r[CMP_B_BIT])
    end
    // async prescaler reset waits for completion
    amode = 1'b1;
    wr_reg(ADDR_SYNC_CTRL, 8'h02);
    idle(3);
    `CHK("async_held", 1'b1, apsr)
    adone = 1'b1;
    idle(2);
    `CHK("async_done", 1'b0, apsr)
    amode = 1'b0;
    wr_reg(ADDR_SYNC_CTRL, 8'h03);
    idle(3);
    `CHK("shared_clear", 1'b0, spsr)
    tally_and_finish;
  end
endmodule
